// >>> design/tws_pkg.sv
// tws_pkg: shared constants and types of the two-wire sensor bus port
package tws_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SAMPLE_PERIOD_US = 228;
  localparam int unsigned SYNC_STEP_US    = 1;
  localparam int unsigned US_CYCLES       = CLK_HZ / 1_000_000;
  localparam int unsigned SAMPLE_CYCLES   = SAMPLE_PERIOD_US * US_CYCLES;
  localparam int unsigned SYNC_STEP_CYCLES = SYNC_STEP_US * US_CYCLES;
  localparam int unsigned BIT_PERIOD_US   = 8;
  localparam int unsigned BIT_CYCLES      = BIT_PERIOD_US * US_CYCLES;
  localparam int unsigned SYNC_VALID_COUNT = 7;

  // ==========================================================
  // apb register map
  localparam logic [7:0] CFG_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TXDATA_OFFSET = 8'h08;
  localparam logic [7:0] ERRCODE_OFFSET = 8'h0c;

  // cfg field positions
  localparam int unsigned CFG_PHASE_BIT  = 0;
  localparam int unsigned CFG_SYNC_BIT   = 1;
  localparam int unsigned CFG_DISCH_BIT  = 2;
  localparam int unsigned CFG_RUN_BIT    = 3;
  localparam logic [3:0]  CFG_RESET      = 4'h0;

  // status field positions
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_ERROR_BIT   = 1;
  localparam int unsigned ST_ARMED_BIT   = 2;
  localparam int unsigned ST_DISCH_BIT   = 3;
  localparam int unsigned ST_VALID_BIT   = 4;

  // ==========================================================
  // transmitter states
  typedef enum logic [4:0] {
    TWS_IDLE  = 5'b00001,
    TWS_START = 5'b00010,
    TWS_DATA  = 5'b00100,
    TWS_STOP  = 5'b01000,
    TWS_WAIT  = 5'b10000
  } tws_tx_state_e;

endpackage : tws_pkg

// >>> design/tws_sync_det.sv
// tws_sync_det: up-down counter validating sync pulses on the bus supply
`timescale 1ns/100ps
`default_nettype none
module tws_sync_det
  import tws_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = SYNC_STEP_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic above_upper_in,
  input  wire logic below_lower_in,
  input  wire logic enable_in,
  input  wire logic rearm_in,
  output logic      valid_out,
  output logic      armed_out
);

  typedef struct packed {
    logic [15:0] step;
    logic [3:0]  count;
    logic        armed;
    logic        hit;
    logic        valid;
  } tws_sd_s;

  tws_sd_s st_ff;
  tws_sd_s nxt_st;

  // ==========================================================
  // counter, blanking and validation
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.valid = 1'b0;
    if (st_ff.step == 16'(STEP_CYCLES - 1)) begin
      nxt_st.step = 16'h0000;
    end else begin
      nxt_st.step = st_ff.step + 16'h0001;
    end
    if (!enable_in) begin
      nxt_st.count = 4'h0;
      nxt_st.armed = 1'b1;
      nxt_st.hit   = 1'b0;
    end else if (st_ff.hit) begin
      nxt_st.valid = 1'b1;
      nxt_st.hit   = 1'b0;
      nxt_st.armed = 1'b0;
      nxt_st.count = 4'h0;
    end else if (!st_ff.armed) begin
      if (rearm_in) begin
        nxt_st.armed = 1'b1;
      end
    end else if (st_ff.step == 16'(STEP_CYCLES - 1)) begin
      if (above_upper_in) begin
        nxt_st.count = st_ff.count + 4'h1;
        if (st_ff.count + 4'h1 == 4'(SYNC_VALID_COUNT)) begin
          nxt_st.hit = 1'b1;
        end
      end else if (below_lower_in && st_ff.count != 4'h0) begin
        nxt_st.count = st_ff.count - 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign valid_out = st_ff.valid;
  assign armed_out = st_ff.armed;

endmodule : tws_sync_det
`default_nettype wire

// >>> design/tws_manch_enc.sv
// tws_manch_enc: manchester half-bit level generator for one bit
`timescale 1ns/100ps
`default_nettype none
module tws_manch_enc
  import tws_pkg::*;
(
  input  wire logic bit_in,
  input  wire logic phase_sel_in,
  input  wire logic second_half_in,
  output logic      level_out
);

  // ==========================================================
  // level = first half opposite of final level; mid edge defines bit
  // phase clear: 1 rises, 0 falls; phase set: inverted
  always_comb begin
    level_out = second_half_in ? (bit_in ^ phase_sel_in)
                               : ~(bit_in ^ phase_sel_in);
  end

endmodule : tws_manch_enc
`default_nettype wire

// >>> design/tws_port.sv
// tws_port: transmit and sync logic of a two-wire sensor bus port
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - phase clear: start 1,0; 0 falls, 1 rises
// - phase set: start 0,0; 0 rises, 1 falls
// - one bit sets phase and start bits
// - reset on low regulator or bus voltage
// - regulator overvoltage raises error
// - sync mode: one conversion per valid pulse
// - hold sample, transmit one period later
// - convert before run phase begins
// - async mode sends frame every 228 us
// - after error send error code repeatedly
// - sync enable selects autonomous or triggered
// - 1 us up-down counter, saturates zero
// - valid the clock after count seven
// - counter blanked after valid pulse
// - rearm after idle bit after frame
// - discharge current on valid sync pulse
// - modulation current while signalling
// - two start bits, one idle stop bit
module tws_port
  import tws_pkg::*;
#(
  parameter int unsigned DATA_BITS    = 10,
  parameter int unsigned BIT_CYC      = BIT_CYCLES,
  parameter int unsigned SAMPLE_CYC   = SAMPLE_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // analog side levels
  input  wire logic        regulator_low_in,
  input  wire logic        bus_voltage_low_in,
  input  wire logic        regulator_over_in,
  input  wire logic        sync_upper_threshold_in,
  input  wire logic        sync_lower_threshold_in,
  input  wire logic [9:0]  adc_result_in,
  output logic             adc_start_out,
  output logic             modulation_current_out,
  output logic             discharge_current_out,
  output logic             frame_start_out
);

  // index width covers the data bit count
  localparam int unsigned BW = $clog2(DATA_BITS + 1);

  // port state, one register bank
  // cfg     : phase, sync, discharge and run bits
  // txdata  : last value written, never sent or read back
  // errcode : word sent instead of data after error
  // held    : conversion result waiting for its frame
  // pending : frame requested, not yet started
  // bitcnt  : cycles into the current bit
  // idx     : bit number within start or data field
  // half    : second half of the current bit
  // period  : free-running sample period timer
  // shreg   : frame data, msb leaves first
  // rdata, ready, slverr: registered bus answer
  // adc, mod, disch, fstart: output levels and pulses; rearm: detector rearm pulse
  typedef struct packed {
    logic [3:0]    cfg;
    logic [9:0]    txdata;
    logic [9:0]    errcode;
    logic [9:0]    held;
    logic          held_ok;
    logic          error;
    logic          pending;
    tws_tx_state_e tx;
    logic [15:0]   bitcnt;
    logic [BW-1:0] idx;
    logic          half;
    logic [15:0]   period;
    logic [9:0]    shreg;
    logic [31:0]   rdata;
    logic          ready;
    logic          slverr;
    logic          adc;
    logic          mod;
    logic          disch;
    logic          fstart;
    logic          rearm;
  } tws_port_s;

  // registered state and its next value
  tws_port_s st_ff;
  tws_port_s nxt_st;

  // helper nets between logic and submodules
  logic sync_valid;
  logic sync_armed;
  logic enc_level;
  logic cur_bit;
  logic pwr_fail;

  // ==========================================================
  // decode helpers
  // address match against one register offset
  function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] o);
    hit_addr = (a == o);
  endfunction : hit_addr

  // start bit value: 1,0 when phase clear, 0,0 when set
  function automatic logic start_bit(input logic ph, input logic [BW-1:0] i);
    start_bit = (i == '0) ? ~ph : 1'b0;
  endfunction : start_bit

  // ==========================================================
  // sync pulse validation
  // detector only listens while sync mode and run are on
  // rearm pulse comes from the transmitter after the idle bit, or at once on a valid pulse with no sample held
  tws_sync_det u_sync (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .above_upper_in (sync_upper_threshold_in),
    .below_lower_in (sync_lower_threshold_in),
    .enable_in      (st_ff.cfg[CFG_SYNC_BIT] & st_ff.cfg[CFG_RUN_BIT]),
    .rearm_in       (st_ff.rearm),
    .valid_out      (sync_valid),
    .armed_out      (sync_armed)
  );

  // current bit and its manchester level
  // start field takes its level from the phase bit
  always_comb begin
    if (st_ff.tx == TWS_START) begin
      cur_bit = start_bit(st_ff.cfg[CFG_PHASE_BIT], st_ff.idx);
    end else begin
      cur_bit = st_ff.shreg[DATA_BITS-1];
    end
  end

  tws_manch_enc u_enc (
    .bit_in         (cur_bit),
    .phase_sel_in   (st_ff.cfg[CFG_PHASE_BIT]),
    .second_half_in (st_ff.half),
    .level_out      (enc_level)
  );

  // supply failure clears frame state, flags and the run bit of the port
  assign pwr_fail = regulator_low_in | bus_voltage_low_in;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ready  = 1'b0;
    nxt_st.slverr = 1'b0;
    nxt_st.adc    = 1'b0;
    nxt_st.fstart = 1'b0;
    nxt_st.rearm  = 1'b0;

    // apb access phase, one wait state
    // pready follows one cycle after the access phase
    // unmapped or read-only targets answer with pslverr
    // reads of unmapped addresses return zero
    if (psel && penable && !st_ff.ready) begin
      nxt_st.ready = 1'b1;
      if (pwrite) begin
        if (hit_addr(paddr, CFG_OFFSET)) begin
          nxt_st.cfg = pwdata[3:0];
        end else if (hit_addr(paddr, TXDATA_OFFSET)) begin
          nxt_st.txdata = pwdata[9:0];
        end else if (hit_addr(paddr, ERRCODE_OFFSET)) begin
          nxt_st.errcode = pwdata[9:0];
        end else begin
          nxt_st.slverr = 1'b1;
        end
      end else begin
        if (hit_addr(paddr, CFG_OFFSET)) begin
          nxt_st.rdata = {28'h0000000, st_ff.cfg};
        end else if (hit_addr(paddr, STATUS_OFFSET)) begin
          nxt_st.rdata = {27'h0000000, st_ff.held_ok, st_ff.disch,
                          sync_armed, st_ff.error,
                          (st_ff.tx != TWS_IDLE)};
        end else if (hit_addr(paddr, TXDATA_OFFSET)) begin
          nxt_st.rdata = {22'h000000, st_ff.held};
        end else if (hit_addr(paddr, ERRCODE_OFFSET)) begin
          nxt_st.rdata = {22'h000000, st_ff.errcode};
        end else begin
          nxt_st.rdata  = 32'h00000000;
          nxt_st.slverr = 1'b1;
        end
      end
    end

    // overvoltage latches the error state
    // error is sticky until the supply drops
    if (regulator_over_in) begin
      nxt_st.error = 1'b1;
    end

    // async sample timer
    // wraps every sample period in any mode
    if (st_ff.period == 16'(SAMPLE_CYC - 1)) begin
      nxt_st.period = 16'h0000;
    end else begin
      nxt_st.period = st_ff.period + 16'h0001;
    end

    // conversion trigger by mode
    if (!st_ff.cfg[CFG_SYNC_BIT]) begin
      if (st_ff.period == 16'(SAMPLE_CYC - 1)) begin
        nxt_st.adc = 1'b1;
        if (st_ff.cfg[CFG_RUN_BIT] && st_ff.held_ok) begin
          nxt_st.pending = 1'b1;
        end
      end
      nxt_st.disch = 1'b0;
    end else if (sync_valid) begin
      // each valid pulse starts one conversion
      // with no sample held yet no frame follows, so
      // the detector is rearmed at once instead
      nxt_st.adc     = 1'b1;
      nxt_st.pending = st_ff.held_ok;
      nxt_st.rearm   = ~st_ff.held_ok;
      nxt_st.disch   = st_ff.cfg[CFG_DISCH_BIT];
    end

    // conversion before run phase keeps held data defined
    if (st_ff.adc) begin
      nxt_st.held    = adc_result_in;
      nxt_st.held_ok = 1'b1;
    end

    // transmitter
    // idle -> start bits -> data bits -> idle bit
    // -> one wait cycle that rearms the detector
    case (st_ff.tx)
      TWS_IDLE: begin
        nxt_st.mod = 1'b0;
        if (st_ff.pending) begin
          nxt_st.pending = 1'b0;
          nxt_st.tx      = TWS_START;
          nxt_st.idx     = '0;
          nxt_st.half    = 1'b0;
          nxt_st.bitcnt  = 16'h0000;
          nxt_st.fstart  = 1'b1;
          // previous sample goes out; error code overrides
          nxt_st.shreg   = st_ff.error ? st_ff.errcode
                                       : st_ff.held;
        end
      end
      TWS_START, TWS_DATA: begin
        // line level lags the state by one register
        nxt_st.mod    = enc_level;
        nxt_st.bitcnt = st_ff.bitcnt + 16'h0001;
        if (st_ff.bitcnt == 16'((BIT_CYC / 2) - 1)) begin
          nxt_st.half = 1'b1;
        end
        // end of bit: next index, shift data out
        if (st_ff.bitcnt == 16'(BIT_CYC - 1)) begin
          nxt_st.bitcnt = 16'h0000;
          nxt_st.half   = 1'b0;
          nxt_st.idx    = st_ff.idx + BW'(1);
          if (st_ff.tx == TWS_DATA) begin
            nxt_st.shreg = {st_ff.shreg[8:0], 1'b0};
          end
          if (st_ff.tx == TWS_START && st_ff.idx == BW'(1)) begin
            nxt_st.tx  = TWS_DATA;
            nxt_st.idx = '0;
          end else if (st_ff.tx == TWS_DATA &&
                       st_ff.idx == BW'(DATA_BITS - 1)) begin
            nxt_st.tx = TWS_STOP;
          end
        end
      end
      TWS_STOP: begin
        // idle bit: no modulation, acts as stop bit
        nxt_st.mod    = 1'b0;
        nxt_st.bitcnt = st_ff.bitcnt + 16'h0001;
        if (st_ff.bitcnt == 16'(BIT_CYC - 1)) begin
          nxt_st.bitcnt = 16'h0000;
          nxt_st.tx     = TWS_WAIT;
        end
      end
      TWS_WAIT: begin
        // discharge ends with the frame
        nxt_st.mod   = 1'b0;
        nxt_st.disch = 1'b0;
        nxt_st.rearm = 1'b1;
        nxt_st.tx    = TWS_IDLE;
      end
      default: begin
        nxt_st.tx = TWS_IDLE;
      end
    endcase

    // supply loss drops frame state, flags and the run bit; rest of config kept
    if (pwr_fail) begin
      nxt_st.tx      = TWS_IDLE;
      nxt_st.mod     = 1'b0;
      nxt_st.disch   = 1'b0;
      nxt_st.pending = 1'b0;
      nxt_st.held_ok = 1'b0;
      nxt_st.error   = 1'b0;
      nxt_st.cfg[CFG_RUN_BIT] = 1'b0;
      // pulses are cut too so nothing leaks out
      nxt_st.fstart  = 1'b0;
      nxt_st.adc     = 1'b0;
      nxt_st.rearm   = 1'b0;
    end
  end

  // state register
  // async reset puts the port in idle, config default
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff     <= '0;
      st_ff.cfg <= CFG_RESET;
      st_ff.tx  <= TWS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  // each output is a field of the state register
  assign prdata                 = st_ff.rdata;
  assign pready                 = st_ff.ready;
  assign pslverr                = st_ff.slverr;
  assign adc_start_out          = st_ff.adc;
  assign modulation_current_out = st_ff.mod;
  assign discharge_current_out  = st_ff.disch;
  assign frame_start_out        = st_ff.fstart;

endmodule : tws_port
`default_nettype wire

// >>> tb/tws_port_checker.sv
// tws_port_checker: port assertions of the sensor bus port
`timescale 1ns/100ps
`default_nettype none
module tws_port_checker
  import tws_pkg::*;
#(
  parameter int unsigned DATA_BITS = 10,
  parameter int unsigned BIT_CYC   = BIT_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic psel,
  input  wire logic penable,
  input  wire logic pready,
  input  wire logic regulator_low_in,
  input  wire logic adc_start_out,
  input  wire logic modulation_current_out,
  input  wire logic discharge_current_out,
  input  wire logic frame_start_out
);
  localparam int FRM = int'((DATA_BITS + 3) * BIT_CYC);
  logic [15:0] adc_gap_ff;
  logic [15:0] frm_gap_ff;
  // ==========================================================
  // cycles since the last conversion start and frame start
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      adc_gap_ff <= 16'hffff;
      frm_gap_ff <= 16'hffff;
    end else begin
      adc_gap_ff <= adc_start_out ? 16'h1 : adc_gap_ff + 16'(~&adc_gap_ff);
      frm_gap_ff <= frame_start_out ? 16'h1 : frm_gap_ff + 16'(~&frm_gap_ff);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================================
  // assertions
  chk_adc_single: assert property (adc_start_out |=> !adc_start_out)
    else $error("conversion start wider than one cycle");
  chk_adc_blank: assert property (adc_start_out |-> adc_gap_ff >= FRM)
    else $error("conversion started inside a frame");
  chk_frame_gap: assert property (frame_start_out |-> frm_gap_ff >= FRM)
    else $error("frame started before idle bit ended");
  chk_start_low: assert property (frame_start_out |-> ##2 !modulation_current_out)
    else $error("first start half not low");
  chk_mod_frame: assert property (modulation_current_out |-> frm_gap_ff <= FRM)
    else $error("modulation outside a frame");
  chk_dis_adc: assert property ($rose(discharge_current_out) |-> adc_start_out)
    else $error("discharge without conversion start");
  chk_reset_quiet: assert property (regulator_low_in [*2] |-> !modulation_current_out && !frame_start_out)
    else $error("activity while supply low");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  cover property (adc_start_out && discharge_current_out);
  cover property (frame_start_out);
  cover property (psel && penable && pready);
endmodule : tws_port_checker
bind tws_port tws_port_checker #(.DATA_BITS(DATA_BITS), .BIT_CYC(BIT_CYC))
  u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel(psel),
  .penable(penable), .pready(pready), .regulator_low_in(regulator_low_in),
  .adc_start_out(adc_start_out),
  .modulation_current_out(modulation_current_out),
  .discharge_current_out(discharge_current_out),
  .frame_start_out(frame_start_out));
`default_nettype wire

// >>> tb/tws_ecu_model.sv
// tws_ecu_model: control module raising sync pulses on the supply
`timescale 1ns/100ps
`default_nettype none
module tws_ecu_model (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_in,
  input  wire logic [15:0] len_in,
  input  wire logic        discharge_in,
  output logic             upper_out,
  output logic             lower_out,
  output logic             busy_out,
  output var logic         ack_out
);
  logic [15:0] cnt_ff;
  // ==========================================================
  // pulse length counter and acknowledge flag
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_ff  <= 16'h0;
      ack_out <= 1'b0;
    end else begin
      if (req_in && !busy_out) begin
        cnt_ff  <= len_in;
        ack_out <= 1'b0;
      end else if (busy_out) begin
        cnt_ff  <= cnt_ff - 16'h1;
      end
      if (discharge_in) begin
        ack_out <= 1'b1;  // discharge taken as acknowledge
      end
    end
  end
  // supply above upper threshold during pulse, below lower threshold after
  assign busy_out  = |cnt_ff;
  assign upper_out = busy_out;
  assign lower_out = ~busy_out;
endmodule : tws_ecu_model
`default_nettype wire

// >>> tb/test_two_wire_sensor_bus_tx_sync.sv
// test_two_wire_sensor_bus_tx_sync: bench of the sensor bus port
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_sensor_bus_tx_sync
  import tws_pkg::*;
;
  localparam int BC = 8;
  localparam int SC = 200;
  logic        clk_in, arst_n_in, psel, penable, pwrite, pready, pslverr;
  logic        reg_low, bus_low, reg_over, upper, lower, req, busy, ack;
  logic        adc_start, mod_cur, dis_cur, frm_start;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  adc;
  logic [15:0] len;
  logic [25:0] exp_q[$];
  int          miscompares = 0, n_tests = 0, seed = 32'h444435c0;
  int          cyc = 0, frames = 0, adcs = 0, last_frm = 0, frm_gap = 0;

  tws_port #(.BIT_CYC(BC), .SAMPLE_CYC(SC)) uut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regulator_low_in(reg_low),
    .bus_voltage_low_in(bus_low), .regulator_over_in(reg_over),
    .sync_upper_threshold_in(upper), .sync_lower_threshold_in(lower),
    .adc_result_in(adc), .adc_start_out(adc_start),
    .modulation_current_out(mod_cur), .discharge_current_out(dis_cur),
    .frame_start_out(frm_start));
  // one device only on this bus
  tws_ecu_model ecu (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req),
    .len_in(len), .discharge_in(dis_cur), .upper_out(upper),
    .lower_out(lower), .busy_out(busy), .ack_out(ack));
  // ==========================================================
  // clock, cycle and conversion counters
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1) adcs <= adcs + 1;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string w, input logic [31:0] x, y);
    n_tests++;
    if (y !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, x, y);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clk_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check("register", x, q & m);
  endtask : rdm
  task automatic pulse(input int steps, input int gap);
    req <= 1'b1;
    len <= 16'(steps * SYNC_STEP_CYCLES);
    @(posedge clk_in);
    req <= 1'b0;
    do @(posedge clk_in); while (busy === 1'b1);
    repeat (gap * SYNC_STEP_CYCLES) @(posedge clk_in);
  endtask : pulse
  task automatic waitf(input int k);
    int f;
    f = frames + k;
    while (frames < f) @(posedge clk_in);
  endtask : waitf
  // half-bit levels of start bits, data and idle bit
  function automatic logic [25:0] enc(input logic p, input logic [9:0] d);
    logic [11:0] b;
    b = {~p, 1'b0, d};
    for (int i = 0; i < 12; i++) begin
      enc[25-2*i] = ~(b[11-i] ^ p);
      enc[24-2*i] = b[11-i] ^ p;
    end
    enc[1:0] = 2'h0;
  endfunction : enc
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // ==========================================================
  // decode each frame mid half-bit, match the oldest note
  initial begin : mon
    logic [25:0] got, x;
    logic        has;
    forever begin
      @(posedge clk_in);
      if (frm_start === 1'b1) begin
        frm_gap = cyc - last_frm;
        last_frm = cyc;
        has = exp_q.size() > 0;
        x = has ? exp_q.pop_front() : 26'h0;
        repeat (2) @(posedge clk_in);
        for (int h = 25; h >= 0; h--) begin
          got[h] = mod_cur;
          repeat (BC / 2) @(posedge clk_in);
        end
        frames++;
        check("frame known", 0, {31'h0, ^got === 1'bx});
        if (has) check("frame", {6'h0, x}, {6'h0, got});
      end
    end
  end
  // cut a hung run short
  initial begin
    repeat (40000) @(posedge clk_in);
    miscompares++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin : main
    logic [9:0] d;
    logic [31:0] q;
    logic        e;
    int          f0, a0;
    static int   sa[2] = '{3, 5};
    static int   ga[2] = '{10, 1};
    static int   sb[2] = '{8, 6};
    {psel, penable, pwrite, reg_low, bus_low, reg_over, req} = 7'h0;
    {paddr, pwdata, adc, len} = 66'h0;
    arst_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    rdm(CFG_OFFSET, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("slverr", 32'h1, {31'h0, e});
    for (int p = 0; p < 2; p++) begin
      d = 10'($random(seed));
      adc <= d;
      wr(CFG_OFFSET, 32'h8 | 32'(p));
      waitf(2);
      exp_q.push_back(enc(p[0], d));
      waitf(2);
      check("period", SC, frm_gap);
    end
    wr(CFG_OFFSET, 32'ha);
    repeat (SC) @(posedge clk_in);
    f0 = frames;
    repeat (3 * SC) @(posedge clk_in);
    check("unsynced frames", f0, frames);
    for (int b = 0; b < 2; b++) begin
      wr(CFG_OFFSET, 32'ha | 32'(b * 4));
      d = 10'($random(seed));
      adc <= d;
      a0 = adcs;
      f0 = frames;
      pulse(9, 4);
      check("adc per sync", 1, adcs - a0);
      check("frame per sync", 1, frames - f0);
      check("discharge", 32'(b), {31'h0, ack});
      pulse(9, 4);
      exp_q.push_back(enc(1'b0, d));
      adc <= ~d;  // new sample must not reach this frame
      pulse(9, 4);
    end
    for (int i = 0; i < 2; i++) begin
      f0 = frames;
      pulse(sa[i], ga[i]);
      pulse(sb[i], 4);
      check("short pulses", 1, frames - f0);
    end
    d = 10'($random(seed));
    wr(ERRCODE_OFFSET, {22'h0, d});
    wr(CFG_OFFSET, 32'h8);
    reg_over <= 1'b1;
    waitf(2);
    reg_over <= 1'b0;
    rdm(STATUS_OFFSET, 32'h2, 32'h2);
    exp_q.push_back(enc(1'b0, d));
    waitf(3);
    for (int s = 0; s < 2; s++) begin
      wr(CFG_OFFSET, 32'h8);
      waitf(1);
      reg_low <= (s == 0);
      bus_low <= (s == 1);
      repeat (4) @(posedge clk_in);
      {reg_low, bus_low} <= 2'h0;
      @(posedge clk_in);
      rdm(CFG_OFFSET, 32'h8, 32'h0);
      rdm(STATUS_OFFSET, 32'h2, 32'h0);
      f0 = frames;
      repeat (2 * SC) @(posedge clk_in);
      check("frames after drop", f0, frames);
    end
    check("pending frames", 0, exp_q.size());
    conclude();
  end
endmodule : test_two_wire_sensor_bus_tx_sync
`default_nettype wire
